// File: rtl/spcg_regs.vh
// register map, frame constants and command codes of the serial prom command gate
`ifndef SPCG_REGS_VH
`define SPCG_REGS_VH

// ----
// register indices and byte addresses
// ----
`define SPCG_GATE_IDX 12'hfea
`define SPCG_GATE_ADDR 14'h3fa8
`define SPCG_STAT_IDX 12'hfe9
`define SPCG_STAT_ADDR 14'h3fa4

// ----
// field positions and reset values
// ----
`define SPCG_GATE_PIN_BIT 0
`define SPCG_GATE_RESET 1'b0
`define SPCG_STAT_PROT_BIT 0
`define SPCG_STAT_NBLK_BIT 1
`define SPCG_STAT_HALT_BIT 2
`define SPCG_STAT_LOOP_BIT 3

// ----
// operation command codes
// ----
`define SPCG_CMD_WRITE 8'h30
`define SPCG_CMD_RAMLOAD 8'h60
`define SPCG_CMD_SUM 8'h90
`define SPCG_CMD_ID 8'hc0
`define SPCG_CMD_STATUS 8'hc3
`define SPCG_CMD_ERASE 8'hf0
`define SPCG_CMD_PROTECT 8'hf4

// ----
// reply frames
// ----
`define SPCG_KIND_ECHO 2'h0
`define SPCG_KIND_ID 2'h1
`define SPCG_KIND_STAT 2'h2
`define SPCG_START_MARK 8'h3a
`define SPCG_ID_COUNT 8'h0a
`define SPCG_ID_ADDR_LEN 8'h02
`define SPCG_ID_BLOCKS 8'h01
`define SPCG_ID_LAST 4'hc
`define SPCG_STAT_COUNT 8'h04
`define SPCG_STAT_LAST 4'h6
`define SPCG_RSVD_BYTE 8'h00

// ----
// flash geometry and password limits
// ----
`define SPCG_ROM_FIRST 16'hc000
`define SPCG_ROM_LAST 16'hffff
`define SPCG_BLANK_FIRST 16'hffe0
`define SPCG_BLANK_COUNT 8'h20
`define SPCG_ERASED_BYTE 8'hff
`define SPCG_PW_MIN 8'h08
`define SPCG_ADDR_BYTES 8'h04

`endif

// File: rtl/spcg_reply_tx.v
// byte sender for the command echo and the identification and status frames
`timescale 1ns/1ps
`default_nettype none
`include "spcg_regs.vh"

module spcg_reply_tx #(
  parameter [7:0] ID_RESERVED = 8'h5a // arbitrary neutral value
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // frame request
  input wire start,
  input wire [1:0] kind,
  input wire [7:0] arg,
  // byte stream towards the uart
  input wire tx_ready,
  output reg tx_valid,
  output reg [7:0] tx_data,
  output wire busy
);

  reg [1:0] kind_r;
  reg [7:0] arg_r;
  reg [3:0] idx_r;
  reg [7:0] sum_r;
  wire [7:0] sum_nxt;
  wire [3:0] last_idx;
  wire [3:0] idx_inc;
  localparam [15:0] ROM_LO = `SPCG_ROM_FIRST;
  localparam [15:0] ROM_HI = `SPCG_ROM_LAST;

  // fixed byte of a frame at a given position
  function [7:0] frame_byte;
    input [1:0] k;
    input [3:0] i;
    input [7:0] a;
    begin
      frame_byte = `SPCG_RSVD_BYTE;
      if (k == `SPCG_KIND_ECHO) begin
        frame_byte = a;
      end else if (k == `SPCG_KIND_ID) begin
        case (i)
          4'h0: frame_byte = `SPCG_START_MARK;
          4'h1: frame_byte = `SPCG_ID_COUNT;
          4'h2: frame_byte = `SPCG_ID_ADDR_LEN;
          4'h3: frame_byte = ID_RESERVED;
          4'h7: frame_byte = `SPCG_ID_BLOCKS;
          4'h8: frame_byte = ROM_LO[15:8];
          4'h9: frame_byte = ROM_LO[7:0];
          4'ha: frame_byte = ROM_HI[15:8];
          4'hb: frame_byte = ROM_HI[7:0];
          default: frame_byte = `SPCG_RSVD_BYTE;
        endcase
      end else begin
        case (i)
          4'h0: frame_byte = `SPCG_START_MARK;
          4'h1: frame_byte = `SPCG_STAT_COUNT;
          4'h2: frame_byte = a;
          default: frame_byte = `SPCG_RSVD_BYTE;
        endcase
      end
    end
  endfunction

  // last position per frame kind
  assign last_idx = (kind_r == `SPCG_KIND_ID) ? `SPCG_ID_LAST :
                    (kind_r == `SPCG_KIND_STAT) ? `SPCG_STAT_LAST : 4'h0;
  assign idx_inc = idx_r + 4'h1;
  // running sum from the third byte onward
  assign sum_nxt = (idx_r >= 4'h2) ? sum_r + tx_data : sum_r;
  assign busy = tx_valid;

  // frame sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_r <= 2'h0;
      arg_r <= 8'h00;
      idx_r <= 4'h0;
      sum_r <= 8'h00;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (start && !tx_valid) begin
      kind_r <= kind;
      arg_r <= arg;
      idx_r <= 4'h0;
      sum_r <= 8'h00;
      tx_data <= frame_byte(kind, 4'h0, arg);
      tx_valid <= 1'b1;
    end else if (tx_valid && tx_ready) begin
      if (idx_r == last_idx) begin
        tx_valid <= 1'b0;
      end else begin
        idx_r <= idx_inc;
        sum_r <= sum_nxt;
        // closing byte makes bytes three onward total zero
        if (idx_inc == last_idx) begin
          tx_data <= 8'h00 - sum_nxt;
        end else begin
          tx_data <= frame_byte(kind_r, idx_inc, arg_r);
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/spcg_gate.v
// serial programming command gate with apb register slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "spcg_regs.vh"

// What this block does
// - password mismatch flags error and halts
// - id frame: 13 bytes, 3ah, 0ah
// - id carries length, block count, rom bounds
// - id checksum zeroes bytes three to twelve
// - status frame: 7 bytes, 3ah, 04h, status
// - status checksum zeroes bytes three to six
// - status shows protect and nonblank flags
// - protection refuses write and ram loader
// - query commands and blank erase need no password
// - nonblank part needs password for guarded commands
// - refused command echoed, then halt
// - start not above end erases sectors
// - start above end: chip erase, unprotect
// - sector erase under protection loops forever
// - sector erase without flash cells halts
// - programming mode fixes non-uart port inputs
// - gate bit resets 0, 1 frees inputs
// - gate register inert outside programming mode
module spcg_gate #(
  parameter PORT_W = 8,
  parameter UART_A_BIT = 3,
  parameter UART_B_BIT = 2,
  parameter [7:0] ID_RESERVED = 8'h5a // arbitrary neutral value
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire [13:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // mode and stored state
  input wire prom_mode,
  input wire protect_stored,
  // uart byte streams
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire tx_ready,
  output wire tx_valid,
  output wire [7:0] tx_data,
  // flash read port, data one cycle after the strobe
  output reg flash_rd,
  output reg [15:0] flash_addr,
  input wire [7:0] flash_rdata,
  // operation engine
  output reg cmd_start,
  output reg [7:0] cmd_code,
  input wire cmd_done,
  output reg erase_chip,
  output reg [15:0] erase_first_address,
  output reg [15:0] erase_last_address,
  // status
  output wire read_protect_flag,
  output wire nonblank,
  output wire halted,
  // ports
  input wire [PORT_W-1:0] port_pins,
  output wire [PORT_W-1:0] port_inputs
);

  // ----
  // states
  // ----
  localparam [3:0] S_SCAN = 4'h0;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_ECHO = 4'h2;
  localparam [3:0] S_ADDR = 4'h3;
  localparam [3:0] S_PWLEN = 4'h4;
  localparam [3:0] S_PWCMP = 4'h5;
  localparam [3:0] S_DISP = 4'h6;
  localparam [3:0] S_ERA = 4'h7;
  localparam [3:0] S_ERDEC = 4'h8;
  localparam [3:0] S_EXEC = 4'h9;
  localparam [3:0] S_REPLY = 4'ha;
  localparam [3:0] S_LOOP = 4'hb;
  localparam [3:0] S_HALT = 4'hc;

  reg [3:0] state_r;
  reg [7:0] cnt_r;
  reg [7:0] cmd_r;
  reg refuse_r;
  reg need_pw_r;
  reg need_addr_r;
  reg [15:0] pw_len_addr_r;
  reg [15:0] pw_orig_r;
  reg [7:0] pw_len_r;
  reg [7:0] rx_hold_r;
  reg rd_q_r;
  reg nonblank_r;
  reg protect_r;
  reg halt_r;
  reg gate_r;
  reg frm_start_r;
  reg [1:0] frm_kind_r;
  reg [7:0] frm_arg_r;
  reg refuse_c;
  reg need_pw_c;
  reg need_addr_c;
  wire frm_valid;
  wire frm_busy;
  wire [7:0] status_code;
  wire [7:0] cnt_inc;
  wire rx_take;

  // ----
  // reply sender
  // ----
  spcg_reply_tx #(
    .ID_RESERVED(ID_RESERVED)
  ) u_reply (
    .pclk(pclk),
    .presetn(presetn),
    .start(frm_start_r),
    .kind(frm_kind_r),
    .arg(frm_arg_r),
    .tx_ready(tx_ready & ~halt_r),
    .tx_valid(frm_valid),
    .tx_data(tx_data),
    .busy(frm_busy)
  );

  // nothing leaves a halted device
  assign tx_valid = frm_valid & ~halt_r;
  assign status_code = {6'h00, nonblank_r, protect_r};
  assign cnt_inc = cnt_r + 8'h01;
  assign rx_take = rx_valid & ~halt_r;
  assign read_protect_flag = protect_r;
  assign nonblank = nonblank_r;
  assign halted = halt_r;

  // ----
  // command admission by protect and blank state
  // ----
  always @* begin
    refuse_c = 1'b0;
    need_pw_c = 1'b0;
    need_addr_c = 1'b0;
    case (rx_data)
      `SPCG_CMD_WRITE, `SPCG_CMD_RAMLOAD: begin
        refuse_c = protect_r;
        need_pw_c = nonblank_r;
        need_addr_c = 1'b1;
      end
      `SPCG_CMD_SUM, `SPCG_CMD_ID, `SPCG_CMD_STATUS: begin
        refuse_c = 1'b0;
      end
      `SPCG_CMD_ERASE: begin
        need_pw_c = nonblank_r;
        need_addr_c = 1'b1;
      end
      `SPCG_CMD_PROTECT: begin
        refuse_c = ~nonblank_r;
        need_pw_c = 1'b1;
        need_addr_c = 1'b1;
      end
      default: begin
        refuse_c = 1'b1;
      end
    endcase
  end

  // ----
  // command sequencer
  // ----
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_SCAN;
      cnt_r <= 8'h00;
      cmd_r <= 8'h00;
      refuse_r <= 1'b0;
      need_pw_r <= 1'b0;
      need_addr_r <= 1'b0;
      pw_len_addr_r <= 16'h0000;
      pw_orig_r <= 16'h0000;
      pw_len_r <= 8'h00;
      rx_hold_r <= 8'h00;
      rd_q_r <= 1'b0;
      flash_rd <= 1'b0;
      flash_addr <= 16'h0000;
      nonblank_r <= 1'b0;
      protect_r <= 1'b0;
      halt_r <= 1'b0;
      frm_start_r <= 1'b0;
      frm_kind_r <= `SPCG_KIND_ECHO;
      frm_arg_r <= 8'h00;
      cmd_start <= 1'b0;
      cmd_code <= 8'h00;
      erase_chip <= 1'b0;
      erase_first_address <= 16'h0000;
      erase_last_address <= 16'h0000;
    end else begin
      flash_rd <= 1'b0;
      rd_q_r <= flash_rd;
      frm_start_r <= 1'b0;
      cmd_start <= 1'b0;
      case (state_r)
        // protect state, then blank check
        S_SCAN: begin
          if (cnt_r == 8'h00) begin
            protect_r <= protect_stored;
          end
          if (cnt_r < `SPCG_BLANK_COUNT) begin
            flash_rd <= 1'b1;
            flash_addr <= `SPCG_BLANK_FIRST + {8'h00, cnt_r};
            cnt_r <= cnt_inc;
          end
          if (rd_q_r && flash_rdata != `SPCG_ERASED_BYTE) begin
            nonblank_r <= 1'b1;
          end
          if (cnt_r == `SPCG_BLANK_COUNT && !flash_rd && !rd_q_r) begin
            state_r <= S_IDLE;
          end
        end
        // every command byte is echoed first
        S_IDLE: begin
          if (rx_take) begin
            cmd_r <= rx_data;
            refuse_r <= refuse_c;
            need_pw_r <= need_pw_c;
            need_addr_r <= need_addr_c;
            frm_kind_r <= `SPCG_KIND_ECHO;
            frm_arg_r <= rx_data;
            frm_start_r <= 1'b1;
            state_r <= S_ECHO;
          end
        end
        S_ECHO: begin
          if (!frm_start_r && !frm_busy) begin
            cnt_r <= 8'h00;
            if (refuse_r) begin
              halt_r <= 1'b1;
              state_r <= S_HALT;
            end else if (need_addr_r) begin
              state_r <= S_ADDR;
            end else if (cmd_r == `SPCG_CMD_ID) begin
              frm_kind_r <= `SPCG_KIND_ID;
              frm_start_r <= 1'b1;
              state_r <= S_REPLY;
            end else if (cmd_r == `SPCG_CMD_STATUS) begin
              frm_kind_r <= `SPCG_KIND_STAT;
              frm_arg_r <= status_code;
              frm_start_r <= 1'b1;
              state_r <= S_REPLY;
            end else begin
              cmd_code <= cmd_r;
              cmd_start <= 1'b1;
              state_r <= S_EXEC;
            end
          end
        end
        // password length location, then compare origin, upper bytes first
        S_ADDR: begin
          if (rx_take) begin
            pw_len_addr_r <= {pw_len_addr_r[7:0], pw_orig_r[15:8]};
            pw_orig_r <= {pw_orig_r[7:0], rx_data};
            cnt_r <= cnt_inc;
            if (cnt_inc == `SPCG_ADDR_BYTES) begin
              cnt_r <= 8'h00;
              state_r <= need_pw_r ? S_PWLEN : S_DISP;
            end
          end
        end
        S_PWLEN: begin
          if (!flash_rd && !rd_q_r) begin
            flash_rd <= 1'b1;
            flash_addr <= pw_len_addr_r;
          end
          if (rd_q_r) begin
            pw_len_r <= flash_rdata;
            if (flash_rdata < `SPCG_PW_MIN) begin
              halt_r <= 1'b1;
              state_r <= S_HALT;
            end else begin
              state_r <= S_PWCMP;
            end
          end
        end
        // each received byte against the flash copy
        S_PWCMP: begin
          if (rx_take && !flash_rd && !rd_q_r) begin
            rx_hold_r <= rx_data;
            flash_rd <= 1'b1;
            flash_addr <= pw_orig_r + {8'h00, cnt_r};
          end
          if (rd_q_r) begin
            if (flash_rdata != rx_hold_r) begin
              halt_r <= 1'b1;
              state_r <= S_HALT;
            end else if (cnt_inc == pw_len_r) begin
              cnt_r <= 8'h00;
              state_r <= S_DISP;
            end else begin
              cnt_r <= cnt_inc;
            end
          end
        end
        S_DISP: begin
          cnt_r <= 8'h00;
          if (cmd_r == `SPCG_CMD_ERASE) begin
            state_r <= S_ERA;
          end else if (cmd_r == `SPCG_CMD_PROTECT) begin
            protect_r <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            cmd_code <= cmd_r;
            cmd_start <= 1'b1;
            state_r <= S_EXEC;
          end
        end
        // erase area, upper bytes first
        S_ERA: begin
          if (rx_take) begin
            erase_first_address <= {erase_first_address[7:0], erase_last_address[15:8]};
            erase_last_address <= {erase_last_address[7:0], rx_data};
            cnt_r <= cnt_inc;
            if (cnt_inc == `SPCG_ADDR_BYTES) begin
              state_r <= S_ERDEC;
            end
          end
        end
        S_ERDEC: begin
          cmd_code <= cmd_r;
          if (erase_first_address > erase_last_address) begin
            erase_chip <= 1'b1;
            protect_r <= 1'b0;
            cmd_start <= 1'b1;
            state_r <= S_EXEC;
          end else if (protect_r) begin
            halt_r <= 1'b1;
            state_r <= S_LOOP;
          end else if (erase_first_address < `SPCG_ROM_FIRST) begin
            halt_r <= 1'b1;
            state_r <= S_HALT;
          end else begin
            erase_chip <= 1'b0;
            cmd_start <= 1'b1;
            state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (!cmd_start && cmd_done) begin
            state_r <= S_IDLE;
          end
        end
        S_REPLY: begin
          if (!frm_start_r && !frm_busy) begin
            state_r <= S_IDLE;
          end
        end
        // only a reset leaves these
        S_LOOP: begin
          state_r <= S_LOOP;
        end
        S_HALT: begin
          state_r <= S_HALT;
        end
        default: begin
          state_r <= S_HALT;
        end
      endcase
    end
  end

  // ----
  // apb slave, zero wait states
  // ----
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr != `SPCG_GATE_ADDR) & (paddr != `SPCG_STAT_ADDR);

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (paddr == `SPCG_GATE_ADDR) begin
        prdata[`SPCG_GATE_PIN_BIT] <= gate_r;
      end else if (paddr == `SPCG_STAT_ADDR) begin
        prdata[`SPCG_STAT_PROT_BIT] <= protect_r;
        prdata[`SPCG_STAT_NBLK_BIT] <= nonblank_r;
        prdata[`SPCG_STAT_HALT_BIT] <= halt_r;
        prdata[`SPCG_STAT_LOOP_BIT] <= (state_r == S_LOOP);
        prdata[7:4] <= state_r;
      end
    end
  end

  // port input gate, writable only in programming mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= `SPCG_GATE_RESET;
    end else if (psel && penable && pwrite && paddr == `SPCG_GATE_ADDR && prom_mode) begin
      gate_r <= pwdata[`SPCG_GATE_PIN_BIT];
    end
  end

  // ----
  // port input fixing
  // ----
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_port
      if (gi == UART_A_BIT || gi == UART_B_BIT) begin : g_uart
        assign port_inputs[gi] = port_pins[gi];
      end else begin : g_fix
        assign port_inputs[gi] = (prom_mode & ~gate_r) ? 1'b0 : port_pins[gi];
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: tb/spcg_gate_asserts.sv
// assertion checker for the serial prom command gate
`timescale 1ns/1ps
`default_nettype none
`include "spcg_regs.vh"
module spcg_gate_asserts #(
  parameter PORT_W = 8,
  parameter UART_A_BIT = 3,
  parameter UART_B_BIT = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [13:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // mode and uart
  input wire logic prom_mode,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  // engine and status
  input wire logic cmd_start,
  input wire logic [7:0] cmd_code,
  input wire logic erase_chip,
  input wire logic [15:0] erase_first_address,
  input wire logic [15:0] erase_last_address,
  input wire logic read_protect_flag,
  input wire logic nonblank,
  input wire logic halted,
  // ports
  input wire logic [PORT_W-1:0] port_pins,
  input wire logic [PORT_W-1:0] port_inputs
);
  logic gate_r, armed_r, hs;
  logic [4:0] idx_r;
  logic [7:0] cnt_r, sum_r;
  logic [PORT_W-1:0] fix_m;
  assign hs = tx_valid & tx_ready;
  assign fix_m = ~(PORT_W'(1) << UART_A_BIT | PORT_W'(1) << UART_B_BIT);
  // ----
  // gate shadow and reply frame tracker
  // ----
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= 1'b0;
      armed_r <= 1'b0;
      idx_r <= 5'h00;
      cnt_r <= 8'h00;
      sum_r <= 8'h00;
    end else begin
      armed_r <= 1'b1;
      if (psel && penable && pwrite && prom_mode && paddr == `SPCG_GATE_ADDR) begin
        gate_r <= pwdata[0];
      end
      if (hs && idx_r == 5'h00 && tx_data == `SPCG_START_MARK) begin
        idx_r <= 5'h01;
      end else if (hs && idx_r == 5'h01) begin
        cnt_r <= tx_data;
        sum_r <= 8'h00;
        idx_r <= 5'h02;
      end else if (hs && idx_r != 5'h00) begin
        sum_r <= sum_r + tx_data;
        idx_r <= ({3'h0, idx_r} == cnt_r + 8'h02) ? 5'h00 : idx_r + 5'h01;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_last;
    hs && idx_r > 5'h01 && {3'h0, idx_r} == cnt_r + 8'h02;
  endsequence
  sequence s_chip;
    cmd_start && erase_chip;
  endsequence
  property p_fix;
    armed_r && $past(armed_r) && prom_mode && !gate_r && $past(prom_mode && !gate_r)
      |-> ((port_inputs ^ $past(port_inputs)) & fix_m) == '0;
  endproperty
  property p_free;
    prom_mode && gate_r |-> port_inputs == port_pins;
  endproperty
  property p_gate_rd;
    armed_r && psel && penable && !pwrite && paddr == `SPCG_GATE_ADDR
      |-> prdata == {31'h0, gate_r};
  endproperty
  property p_silent;
    halted |-> !tx_valid;
  endproperty
  property p_sticky;
    halted |=> halted;
  endproperty
  property p_count;
    hs && idx_r == 5'h01 |-> tx_data == `SPCG_ID_COUNT || tx_data == `SPCG_STAT_COUNT;
  endproperty
  property p_idlen;
    hs && idx_r == 5'h02 && cnt_r == `SPCG_ID_COUNT |-> tx_data == `SPCG_ID_ADDR_LEN;
  endproperty
  property p_sts;
    hs && idx_r == 5'h02 && cnt_r == `SPCG_STAT_COUNT
      |-> tx_data == {6'h00, nonblank, read_protect_flag};
  endproperty
  property p_sum;
    s_last |-> sum_r + tx_data == 8'h00;
  endproperty
  property p_refuse;
    cmd_start |-> !(read_protect_flag && (cmd_code == 8'h30 || cmd_code == 8'h60));
  endproperty
  property p_sector;
    cmd_start && cmd_code == 8'hf0 && !erase_chip |-> erase_first_address <= erase_last_address;
  endproperty
  property p_chip;
    s_chip |-> (erase_first_address > erase_last_address) ##[1:40] !read_protect_flag;
  endproperty
  a_fix: assert property (p_fix) else $error("fixed port inputs moved");
  a_free: assert property (p_free) else $error("port inputs not passed");
  a_gate_rd: assert property (p_gate_rd) else $error("gate readback wrong");
  a_silent: assert property (p_silent) else $error("byte sent while halted");
  a_sticky: assert property (p_sticky) else $error("halt left without reset");
  a_count: assert property (p_count) else $error("frame count byte wrong");
  a_idlen: assert property (p_idlen) else $error("id length byte wrong");
  a_sts: assert property (p_sts) else $error("status byte wrong");
  a_sum: assert property (p_sum) else $error("frame checksum wrong");
  a_refuse: assert property (p_refuse) else $error("protected command started");
  a_sector: assert property (p_sector) else $error("sector bounds wrong");
  a_chip: assert property (p_chip) else $error("chip erase kept protection");
endmodule
bind spcg_gate spcg_gate_asserts #(.PORT_W(PORT_W), .UART_A_BIT(UART_A_BIT),
  .UART_B_BIT(UART_B_BIT)) i_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .prom_mode, .tx_valid, .tx_ready, .tx_data, .cmd_start, .cmd_code,
  .erase_chip, .erase_first_address, .erase_last_address, .read_protect_flag, .nonblank,
  .halted, .port_pins, .port_inputs);
`default_nettype wire

// File: tb/spcg_ctl_model.sv
// uart controller model
`timescale 1ns/1ps
`default_nettype none
module spcg_ctl_model (
  // clock
  input wire logic pclk,
  // byte streams
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  logic slow = 1'b0;
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // take replies
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // one byte pulse
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    repeat (10) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// File: tb/spcg_gate_tb_top.sv
// self-checking bench for the serial prom command gate
`timescale 1ns/1ps
`default_nettype none
`include "spcg_regs.vh"
module spcg_gate_tb_top;
  localparam [7:0] ID_RESV = 8'h36; // arbitrary neutral value
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, perr, rx_valid, tx_ready, tx_valid, flash_rd, cmd_start, erase_chip;
  logic prom_mode = 1'b0, protect_stored = 1'b0, cmd_done = 1'b0, eng_d = 1'b0, blank;
  logic [7:0] rx_data, tx_data, cmd_code, s, flash_rdata = 8'h00, port_pins = 8'h00;
  logic [7:0] port_inputs, exp_q[$];
  logic [15:0] flash_addr, erase_first_address, erase_last_address, st_first, st_last;
  logic read_protect_flag, nonblank, halted, st_chip;
  logic [7:0] rc[3] = '{8'h30, 8'h60, 8'hf4};
  logic rb[3] = '{1'b1, 1'b0, 1'b1};
  logic rp[3] = '{1'b1, 1'b1, 1'b0};
  int err_total = 0, n_tests = 0, cyc = 0;
  spcg_gate #(.ID_RESERVED(ID_RESV)) i_dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .prom_mode, .protect_stored, .rx_valid,
    .rx_data, .tx_ready, .tx_valid, .tx_data, .flash_rd, .flash_addr, .flash_rdata,
    .cmd_start, .cmd_code, .cmd_done, .erase_chip, .erase_first_address,
    .erase_last_address, .read_protect_flag, .nonblank, .halted, .port_pins, .port_inputs);
  spcg_ctl_model i_ctl (.pclk, .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data);
  initial forever #20 pclk = ~pclk;
  // flash image
  function automatic logic [7:0] rom(input logic [15:0] a);
    if (a >= `SPCG_BLANK_FIRST) return blank ? 8'hff : 8'h00;
    if (a == 16'hf000) return 8'h08;
    if (a > 16'hf000 && a < 16'hf009) return 8'h40 + a[7:0];
    return 8'hff;
  endfunction
  // flash, engine, timeout
  always @(posedge pclk) begin
    flash_rdata <= flash_rd ? rom(flash_addr) : ~flash_rdata;
    eng_d <= cmd_start;
    cmd_done <= eng_d;
    if (cmd_start) begin
      st_chip <= erase_chip;
      st_first <= erase_first_address;
      st_last <= erase_last_address;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [13:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic boot(input logic b, input logic p);
    blank = b;
    protect_stored <= p;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (45) @(posedge pclk);
    i_ctl.got.delete();
  endtask
  // command with optional fields
  task automatic seq(input logic [7:0] c, input logic [2:0] m, input logic [31:0] tail);
    i_ctl.send(c);
    if (m[0]) for (int i = 0; i < 4; i++) i_ctl.send(i[0] ? {7'h00, i[1]} : 8'hf0);
    if (m[1]) for (int i = 1; i < 9; i++) i_ctl.send(8'h40 + 8'(i) - {7'h0, m == 3'b011});
    if (m[2]) for (int i = 3; i >= 0; i--) i_ctl.send(tail[i*8 +: 8]);
    repeat (60) @(posedge pclk);
    chk(i_ctl.got[0], c);
  endtask
  task automatic expect_q();
    for (int n = 0; n < 400 && i_ctl.got.size() < exp_q.size(); n++) @(posedge pclk);
    repeat (40) @(posedge pclk);
    chk(i_ctl.got.size(), exp_q.size());
    foreach (exp_q[i]) chk(i_ctl.got[i], exp_q[i]);
    i_ctl.got.delete();
  endtask
  initial begin
    boot(1'b1, 1'b0);
    prom_mode <= 1'b1;
    port_pins <= 8'ha5;
    apb(`SPCG_GATE_ADDR, 1'b0, 32'h0);
    chk(q, 32'h0);
    s = port_inputs;
    port_pins <= 8'h5a;
    @(posedge pclk);
    chk((port_inputs ^ s) & 8'hf3, 32'h0);
    chk(port_inputs[3:2], 2'b10);
    apb(`SPCG_GATE_ADDR, 1'b1, 32'h1);
    @(posedge pclk);
    chk(port_inputs, port_pins);
    prom_mode <= 1'b0;
    apb(`SPCG_GATE_ADDR, 1'b1, 32'h0);
    prom_mode <= 1'b1;
    apb(`SPCG_GATE_ADDR, 1'b0, 32'h0);
    chk(q, 32'h1);
    apb(14'h0000, 1'b0, 32'h0);
    chk(perr, 1'b1);
    for (int k = 0; k < 4; k++) begin
      boot(~k[1], k[0]);
      i_ctl.slow <= k[0];
      chk({nonblank, read_protect_flag}, k[1:0]);
      seq(`SPCG_CMD_ID, 3'b000, 32'h0);
      exp_q = '{8'hc0, 8'h3a, 8'h0a, 8'h02, ID_RESV, 8'h00, 8'h00, 8'h00, 8'h01, 8'hc0,
        8'h00, 8'hff, 8'hff};
      s = 8'h00;
      for (int i = 3; i < 13; i++) s += exp_q[i];
      exp_q.push_back(8'h00 - s);
      expect_q();
      seq(`SPCG_CMD_STATUS, 3'b000, 32'h0);
      exp_q = '{8'hc3, 8'h3a, 8'h04, 8'(k), 8'h00, 8'h00, 8'h00, 8'h00 - 8'(k)};
      expect_q();
    end
    i_ctl.slow <= 1'b0;
    foreach (rc[i]) begin
      boot(rb[i], rp[i]);
      seq(rc[i], 3'b000, 32'h0);
      i_ctl.send(`SPCG_CMD_ID);
      exp_q = '{rc[i]};
      expect_q();
      chk(halted, 1'b1);
    end
    boot(1'b0, 1'b0);
    seq(`SPCG_CMD_ERASE, 3'b011, 32'h0);
    chk(halted, 1'b1);
    boot(1'b0, 1'b0);
    seq(`SPCG_CMD_PROTECT, 3'b111, 32'h0);
    chk(read_protect_flag, 1'b1);
    boot(1'b0, 1'b1);
    seq(`SPCG_CMD_ERASE, 3'b111, 32'hffffc000);
    chk(st_chip, 1'b1);
    chk(read_protect_flag, 1'b0);
    boot(1'b0, 1'b0);
    seq(`SPCG_CMD_ERASE, 3'b111, 32'hc000cfff);
    chk(st_chip, 1'b0);
    chk({st_first, st_last}, 32'hc000cfff);
    boot(1'b0, 1'b0);
    seq(`SPCG_CMD_ERASE, 3'b111, 32'h00000fff);
    chk(halted, 1'b1);
    boot(1'b0, 1'b1);
    seq(`SPCG_CMD_ERASE, 3'b111, 32'hc000cfff);
    apb(`SPCG_STAT_ADDR, 1'b0, 32'h0);
    chk(q[3:0], 4'hf);
    end_sim();
  end
endmodule
`default_nettype wire
